// *** core/dco_ctrl.sv ***
// dco_ctrl: dc-offset calibration control word and its loop control.
// assumes wr_valid marks a complete 32-bit word from the serial front end.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - writing 1 to bit 5 starts rx calibration; bit self-clears when done.
// - writing 1 to bit 18 starts xpol calibration; bit self-clears when done.
// - bits 14-16 set rx correction-loop clock divide ratio.
// - bits 27-29 set xpol correction-loop clock divide ratio.
// - bit 31 high powers down xpol loop; resets to active.
// - bit 17 high enables rx baseband offset loop; resets to 0.
// - bits 12-13 give rx correction dac range; reset value 11.
// - bits 25-26 give xpol correction dac range; reset value 11.
// - rx demod current, i and q mixer bias codes held and driven out.
// - xpol demod current, i and q mixer bias codes held and driven out.
module dco_ctrl #(
    parameter int CAL_LEN = dco_pkg::CAL_TICKS
) (
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    input  wire logic                       wr_valid,
    input  wire logic [dco_pkg::WORD_W-1:0] wr_data,
    input  wire logic                       div_tick,
    output logic      [dco_pkg::WORD_W-1:0] ctrl_word,
    output logic                            rx_loop_active,
    output logic                            xpol_loop_active,
    output logic                            rx_loop_tick,
    output logic                            xpol_loop_tick,
    output logic                            rx_cal_busy,
    output logic                            xpol_cal_busy,
    output logic      [1:0]                 rx_offset_dac_range,
    output logic      [1:0]                 xpol_offset_dac_range,
    output logic      [1:0]                 rx_demod_current,
    output logic      [1:0]                 rx_inphase_mixer_bias,
    output logic      [1:0]                 rx_quadrature_mixer_bias,
    output logic      [1:0]                 xpol_demod_current,
    output logic      [1:0]                 xpol_inphase_mixer_bias,
    output logic      [1:0]                 xpol_quadrature_mixer_bias
);
    import dco_pkg::*;

    logic [WORD_W-1:0] next_ctrl_word;
    logic              hit;
    logic              rx_start;
    logic              xpol_start;
    logic              rx_done;
    logic              xpol_done;
    logic              rx_busy_int;
    logic              xpol_busy_int;
    logic              rx_tick_int;
    logic              xpol_tick_int;

    // words for other registers are ignored
    assign hit        = wr_valid && (wr_data[ADDR_LSB +: ADDR_W] == CTRL_ADDR_CODE);
    assign rx_start   = hit && wr_data[RX_CAL_POS];
    assign xpol_start = hit && wr_data[XP_CAL_POS];

    always_comb begin
        next_ctrl_word = ctrl_word;
        if (rx_done) begin
            next_ctrl_word[RX_CAL_POS] = 1'b0;
        end
        if (xpol_done) begin
            next_ctrl_word[XP_CAL_POS] = 1'b0;
        end
        // a fresh write lands after the clear, so a start written in the same cycle as rx_done or xpol_done is kept
        if (hit) begin
            next_ctrl_word = wr_data;
            if (!wr_data[RX_CAL_POS] && rx_busy_int && !rx_done) begin
                next_ctrl_word[RX_CAL_POS] = 1'b1;
            end
            if (!wr_data[XP_CAL_POS] && xpol_busy_int && !xpol_done) begin
                next_ctrl_word[XP_CAL_POS] = 1'b1;
            end
        end
    end

    // rx loop clock divider and calibration
    dco_loop_unit #(
        .CAL_LEN (CAL_LEN)
    ) u_rx_loop (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .div_tick   (div_tick),
        .divide_sel (ctrl_word[RX_DIV_LSB +: DIV_W]),
        .cal_start  (rx_start),
        .loop_tick  (rx_tick_int),
        .cal_busy   (rx_busy_int),
        .cal_done   (rx_done)
    );

    // xpol loop clock divider and calibration
    dco_loop_unit #(
        .CAL_LEN (CAL_LEN)
    ) u_xpol_loop (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .div_tick   (div_tick),
        .divide_sel (ctrl_word[XP_DIV_LSB +: DIV_W]),
        .cal_start  (xpol_start),
        .loop_tick  (xpol_tick_int),
        .cal_busy   (xpol_busy_int),
        .cal_done   (xpol_done)
    );

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            // ranges reset to 11 within the reset word
            ctrl_word        <= CTRL_RESET;
            rx_loop_active   <= CTRL_RESET[RX_LOOP_EN_POS];
            xpol_loop_active <= !CTRL_RESET[XP_PWD_POS];
            rx_loop_tick     <= 1'b0;
            xpol_loop_tick   <= 1'b0;
            rx_cal_busy      <= 1'b0;
            xpol_cal_busy    <= 1'b0;
        end else begin
            ctrl_word        <= next_ctrl_word;
            rx_loop_active   <= next_ctrl_word[RX_LOOP_EN_POS];
            xpol_loop_active <= !next_ctrl_word[XP_PWD_POS];
            rx_loop_tick     <= rx_tick_int;
            xpol_loop_tick   <= xpol_tick_int;
            rx_cal_busy      <= rx_busy_int;
            xpol_cal_busy    <= xpol_busy_int;
        end
    end

    // field views are slices of the control flop, no extra logic
    // rx dac range
    assign rx_offset_dac_range        = ctrl_word[RX_RANGE_LSB +: 2];
    assign xpol_offset_dac_range      = ctrl_word[XP_RANGE_LSB +: 2];
    assign rx_demod_current           = ctrl_word[RX_DEMOD_LSB +: 2];
    assign rx_inphase_mixer_bias      = ctrl_word[RX_IMIX_LSB +: 2];
    assign rx_quadrature_mixer_bias   = ctrl_word[RX_QMIX_LSB +: 2];
    assign xpol_demod_current         = ctrl_word[XP_DEMOD_LSB +: 2];
    assign xpol_inphase_mixer_bias    = ctrl_word[XP_IMIX_LSB +: 2];
    assign xpol_quadrature_mixer_bias = ctrl_word[XP_QMIX_LSB +: 2];
endmodule : dco_ctrl
`default_nettype wire

// *** core/dco_pkg.sv ***
// dco_pkg: constants for the dc-offset calibration control word.
// assumes a 32-bit word delivered whole by the serial front end.
package dco_pkg;
    localparam int          WORD_W          = 32;
    localparam logic [31:0] CTRL_RESET      = 32'h67493a5d;
    localparam logic [4:0]  CTRL_ADDR_CODE  = 5'h1d;
    localparam int          ADDR_LSB        = 0;
    localparam int          ADDR_W          = 5;
    localparam int          RX_CAL_POS      = 5;
    localparam int          RX_DEMOD_LSB    = 6;
    localparam int          RX_IMIX_LSB     = 8;
    localparam int          RX_QMIX_LSB     = 10;
    localparam int          RX_RANGE_LSB    = 12;
    localparam int          RX_DIV_LSB      = 14;
    localparam int          RX_LOOP_EN_POS  = 17;
    localparam int          XP_CAL_POS      = 18;
    localparam int          XP_DEMOD_LSB    = 19;
    localparam int          XP_IMIX_LSB     = 21;
    localparam int          XP_QMIX_LSB     = 23;
    localparam int          XP_RANGE_LSB    = 25;
    localparam int          XP_DIV_LSB      = 27;
    localparam int          XP_PWD_POS      = 31;
    localparam int          DIV_W           = 3;
    localparam int          CNT_W           = 8;
    localparam int          CAL_TICKS       = 64;
endpackage : dco_pkg

// *** core/dco_loop_unit.sv ***
// dco_loop_unit: loop clock divider and autocalibration sequencer.
// assumes div_tick is a one-cycle pulse from the internal clock divider.
`timescale 1ns/100ps
`default_nettype none
module dco_loop_unit #(
    parameter int CAL_LEN = dco_pkg::CAL_TICKS
) (
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    input  wire logic                      div_tick,
    input  wire logic [dco_pkg::DIV_W-1:0] divide_sel,
    input  wire logic                      cal_start,
    output logic                           loop_tick,
    output logic                           cal_busy,
    output logic                           cal_done
);
    import dco_pkg::*;

    typedef enum logic [0:0] {DCO_IDLE, DCO_RUN} dco_cal_state_t;

    dco_cal_state_t     state,     next_state;
    logic [CNT_W-1:0]   div_cnt,   next_div_cnt;
    logic [CNT_W-1:0]   cal_cnt,   next_cal_cnt;
    logic               next_loop_tick;
    logic               next_cal_done;
    logic               next_cal_busy;
    logic [CNT_W-1:0]   div_last;

    // divide ratio is a power of two of the select field
    assign div_last = CNT_W'((1 << divide_sel) - 1);

    always_comb begin
        next_div_cnt   = div_cnt;
        next_loop_tick = 1'b0;
        if (div_tick) begin
            if (div_cnt >= div_last) begin
                next_div_cnt   = '0;
                next_loop_tick = 1'b1;
            end else begin
                next_div_cnt = CNT_W'(div_cnt + 1'b1);
            end
        end
    end

    always_comb begin
        next_state    = state;
        next_cal_cnt  = cal_cnt;
        next_cal_done = 1'b0;
        unique case (state)
            DCO_IDLE: begin
                if (cal_start) begin
                    next_state   = DCO_RUN;
                    next_cal_cnt = '0;
                end
            end
            DCO_RUN: begin
                // calibration paced by the loop clock it tunes
                if (loop_tick) begin
                    if (cal_cnt == CNT_W'(CAL_LEN - 1)) begin
                        next_state    = DCO_IDLE;
                        next_cal_done = 1'b1;
                    end else begin
                        next_cal_cnt = CNT_W'(cal_cnt + 1'b1);
                    end
                end
            end
        endcase
        // busy tracks the state it will hold after this edge
        next_cal_busy = (next_state == DCO_RUN);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state     <= DCO_IDLE;
            div_cnt   <= '0;
            cal_cnt   <= '0;
            loop_tick <= 1'b0;
            cal_done  <= 1'b0;
            cal_busy  <= 1'b0;
        end else begin
            state     <= next_state;
            div_cnt   <= next_div_cnt;
            cal_cnt   <= next_cal_cnt;
            loop_tick <= next_loop_tick;
            cal_done  <= next_cal_done;
            cal_busy  <= next_cal_busy;
        end
    end
endmodule : dco_loop_unit
`default_nettype wire

// *** verif/dco_props.sv ***
// dco_props: assertions on the control word ports.
// assumes one clock domain, bound to dco_ctrl.
`timescale 1ns/100ps
`default_nettype none
module dco_props
    import dco_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        wr_valid,
    input wire logic [31:0] wr_data,
    input wire logic        div_tick,
    input wire logic [31:0] ctrl_word,
    input wire logic        rx_loop_active,
    input wire logic        xpol_loop_active,
    input wire logic        rx_loop_tick,
    input wire logic        rx_cal_busy,
    input wire logic        xpol_loop_tick,
    input wire logic        xpol_cal_busy,
    input wire logic [1:0]  rx_offset_dac_range
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence take_s; wr_valid && wr_data[4:0] == CTRL_ADDR_CODE; endsequence
    sequence run_s; ctrl_word[5] ##1 rx_cal_busy; endsequence
    sequence xrun_s; ctrl_word[18] ##1 xpol_cal_busy; endsequence
    word_take_a: assert property (take_s |=> {ctrl_word[31:19], ctrl_word[17:6]} ==
        $past({wr_data[31:19], wr_data[17:6]})) else $error("word not stored");
    rx_start_a: assert property (take_s ##0 wr_data[5] |=> run_s)
        else $error("rx calibration not started");
    xp_start_a: assert property (take_s ##0 wr_data[18] |=> xrun_s)
        else $error("xpol calibration not started");
    rx_clear_a: assert property ($fell(ctrl_word[5]) |=> !rx_cal_busy)
        else $error("rx busy outlives its bit");
    rx_enable_a: assert property (rx_loop_active == ctrl_word[17])
        else $error("rx loop enable wrong");
    xp_power_a: assert property (xpol_loop_active == !ctrl_word[31])
        else $error("xpol power state wrong");
    rx_range_a: assert property (rx_offset_dac_range == ctrl_word[13:12])
        else $error("rx dac range wrong");
    rx_tick_a: assert property (rx_loop_tick |-> $past(div_tick, 2))
        else $error("loop tick without divider tick");
    xp_tick_a: assert property (xpol_loop_tick |-> $past(div_tick, 2))
        else $error("xpol tick without divider tick");
    // divide select of zero passes every divider tick
    rx_div_a: assert property (div_tick && ctrl_word[16:14] == '0 |=> ##1 rx_loop_tick)
        else $error("rx loop tick missing at divide one");
    xp_div_a: assert property (div_tick && ctrl_word[29:27] == '0 |=> ##1 xpol_loop_tick)
        else $error("xpol loop tick missing at divide one");
endmodule : dco_props
bind dco_ctrl dco_props u_props (.sys_clk, .reset, .wr_valid, .wr_data, .div_tick, .ctrl_word,
    .rx_loop_active, .xpol_loop_active, .rx_loop_tick, .rx_cal_busy, .xpol_loop_tick,
    .xpol_cal_busy, .rx_offset_dac_range);
`default_nettype wire

// *** verif/dco_host.sv ***
// dco_host: host model writing whole control words.
// assumes send is called just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module dco_host
    import dco_pkg::*;
(
    input  wire logic        sys_clk,
    output var  logic        wr_valid,
    output var  logic [31:0] wr_data
);
    initial begin
        wr_valid = 1'b0;
        wr_data  = 32'h0;
    end
    task automatic send(input logic [31:0] w, input logic good, output logic [31:0] sent);
        sent = {w[31], 1'b1, w[29:5], good ? CTRL_ADDR_CODE : ~CTRL_ADDR_CODE};
        @(posedge sys_clk);
        #1 wr_valid = 1'b1;
        wr_data = sent;
        @(posedge sys_clk);
        #1 wr_valid = 1'b0;
        // flipped so stale data of a good write no longer carries the control address
        wr_data = ~sent;
    endtask : send
endmodule : dco_host
`default_nettype wire

// *** verif/testbench.sv ***
// testbench: random and calibration writes checked against a model.
// assumes CAL_LEN cut to 2 loop ticks.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import dco_pkg::*;
    logic             sys_clk;
    logic             reset;
    logic             div_tick;
    logic [31:0]      m;
    logic [31:0]      seed;
    logic [31:0]      sent;
    int               n_fail;
    int               compares;
    wire logic        wr_valid;
    wire logic [31:0] wr_data;
    wire logic [31:0] ctrl_word;
    wire logic [1:0]  act;
    wire logic [1:0]  busy;
    wire logic [15:0] fld;
    dco_host u_host (.sys_clk(sys_clk), .wr_valid(wr_valid), .wr_data(wr_data));
    dco_ctrl #(.CAL_LEN(2)) u_dut (.sys_clk(sys_clk), .reset(reset), .wr_valid(wr_valid),
        .wr_data(wr_data), .div_tick(div_tick), .ctrl_word(ctrl_word), .rx_loop_active(act[0]),
        .xpol_loop_active(act[1]), .rx_loop_tick(), .xpol_loop_tick(), .rx_cal_busy(busy[0]),
        .xpol_cal_busy(busy[1]), .rx_offset_dac_range(fld[15:14]),
        .xpol_offset_dac_range(fld[13:12]), .rx_demod_current(fld[11:10]),
        .rx_inphase_mixer_bias(fld[9:8]), .rx_quadrature_mixer_bias(fld[7:6]),
        .xpol_demod_current(fld[5:4]), .xpol_inphase_mixer_bias(fld[3:2]),
        .xpol_quadrature_mixer_bias(fld[1:0]));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // expected range and bias outputs, in the order of fld
    function automatic logic [31:0] fields(input logic [31:0] w);
        return {16'h0, w[13:12], w[26:25], w[7:6], w[9:8], w[11:10],
                w[20:19], w[22:21], w[24:23]};
    endfunction : fields
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("n_fail=%0d compares=%0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [31:0] w, input logic good);
        u_host.send(w, good, sent);
        // running start bits stay set, foreign addresses ignored
        if (good) m = {sent[31:19], sent[18] | m[18], sent[17:6], sent[5] | m[5], sent[4:0]};
        chk(ctrl_word, m);
        chk({30'h0, act}, {30'h0, !m[31], m[17]});
        chk({16'h0, fld}, fields(m));
    endtask : wr
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        div_tick = 1'b0;
        forever begin
            repeat (4) @(posedge sys_clk);
            #1 div_tick = 1'b1;
            @(posedge sys_clk);
            #1 div_tick = 1'b0;
        end
    end
    initial begin
        #200000;
        n_fail++;
        end_of_test();
    end
    initial begin
        reset = 1'b1;
        seed = 32'd26470;
        n_fail = 0;
        compares = 0;
        m = 32'h67493a5d;
        repeat (16) @(posedge sys_clk);
        #1 reset = 1'b0;
        chk(ctrl_word, m);
        chk({30'h0, act}, {30'h0, !m[31], m[17]});
        chk({16'h0, fld}, fields(m));
        for (int i = 0; i < 40; i++) wr(xs() & ~32'h00040020, (xs() % 4) != 0);
        for (int k = 0; k < 2; k++) begin
            int p;
            p = k ? XP_CAL_POS : RX_CAL_POS;
            wr(32'h1 << p, 1'b1);
            // clearing a running start bit is refused
            wr(32'h0, 1'b1);
            chk({31'h0, busy[k]}, 32'h1);
            // look off the edge so the clear is never raced
            for (int t = 0; t < 200 && ctrl_word[p] === 1'b1; t++) begin
                @(posedge sys_clk);
                #1;
            end
            m[p] = 1'b0;
            chk(ctrl_word, m);
            chk({31'h0, busy[k]}, 32'h0);
        end
        // reset in mid calibration drops the run and restores the word
        wr(32'h1 << RX_CAL_POS, 1'b1);
        reset = 1'b1;
        m = CTRL_RESET;
        #1 chk(ctrl_word, m);
        repeat (2) @(posedge sys_clk);
        #1 reset = 1'b0;
        chk({30'h0, busy}, 32'h0);
        chk({30'h0, act}, {30'h0, !m[31], m[17]});
        wr(xs() & ~32'h00040020, 1'b1);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
